// file: core/drc_defines.svh
/*
 Offsets, field positions, reset values and timing constants of the drive
 output and serial supervision block. Assumes an 8-bit APB byte address.
*/
`ifndef DRC_DEFINES_SVH
`define DRC_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define DRC_OFF_CAUSE 8'h00
`define DRC_OFF_OUTSTAT 8'h04
`define DRC_OFF_INPOL 8'h08
`define DRC_OFF_ON_DLY 8'h0C
`define DRC_OFF_OFF_DLY 8'h10
`define DRC_OFF_FAN 8'h14
`define DRC_OFF_AUXFN 8'h18
`define DRC_OFF_COMM 8'h1C
`define DRC_OFF_TIMEOUT 8'h20
`define DRC_OFF_SDELAY 8'h24
`define DRC_OFF_STATUS 8'h28
`define DRC_OFF_IRQ_STAT 8'h2C
`define DRC_OFF_IRQ_MASK 8'h30

// ==========================================================
// Reset values
`define DRC_RST_CAUSE 3'h2
`define DRC_RST_INPOL 8'h00
`define DRC_RST_RELAY_DLY 16'h0000
`define DRC_RST_FAN_MODE 2'h0
`define DRC_RST_FAN_TEMP 7'h46
`define DRC_FAN_TEMP_MAX 7'h46
`define DRC_RST_STATION 8'h01
`define DRC_RST_BAUD 3'h3
`define DRC_RST_LOSS_ACT 2'h0
`define DRC_RST_TIMEOUT_MS 16'h03E8
`define DRC_RST_SDELAY_MS 8'h05

// ==========================================================
// Field positions
`define DRC_CB_UV 0
`define DRC_CB_TRIP 1
`define DRC_CB_RETRY 2
`define DRC_IRQ_LOST 0
`define DRC_IRQ_RELAY 1
`define DRC_IRQ_RESTORE 2
`define DRC_CODE_NONE 2'h0
`define DRC_CODE_UV 2'h1
`define DRC_CODE_TRIP 2'h2
`define DRC_CODE_RETRY 2'h3

// ==========================================================
// Timing
`define DRC_CLK_PERIOD_NS 5
`define DRC_TICK_NS 1000000

`endif

// file: core/drc_pkg.sv
/*
 Types of the drive output and serial supervision block.
 Assumes drc_defines.svh is available on the include path.
*/
package drc_pkg;
	// ==========================================================
	// Modes and states
	typedef enum logic [1:0] {DRC_FAN_ALWAYS, DRC_FAN_RUN, DRC_FAN_TEMP} drc_fan_mode_t;
	typedef enum logic [1:0] {DRC_LOSS_NONE, DRC_LOSS_COAST, DRC_LOSS_STOP} drc_loss_t;
	typedef enum logic [1:0] {DRC_LINK_IDLE, DRC_LINK_OK, DRC_LINK_LOST} drc_link_t;
endpackage

// file: core/drc_tick.sv
/*
 Divider giving a one-cycle enable pulse every DIV clocks.
 Assumes one free-running clock and an asynchronous high reset.
*/
`timescale 1ns/1ps
module drc_tick #(
	parameter int DIV = 200000
) (
	input wire logic clk, // Core clock
	input wire logic rst, // Async reset, high
	output logic tick // One-cycle pulse
);
	localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	logic [W-1:0] cnt_reg; // Divider count
	logic [W-1:0] cnt_next;
	logic tick_reg; // Registered pulse
	logic tick_next;

	// ==========================================================
	// Count and wrap
	always_comb begin
		tick_next = (cnt_reg == LAST);
		cnt_next = tick_next ? '0 : cnt_reg + 1'b1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule

// file: core/drc_delay.sv
/*
 On/off delay of the fault relay, counted in millisecond ticks.
 Assumes tick is a one-cycle pulse from the same clock.
*/
`timescale 1ns/1ps
module drc_delay #(
	parameter int W = 16
) (
	input wire logic clk, // Core clock
	input wire logic rst, // Async reset, high
	input wire logic tick, // Millisecond enable
	input wire logic req, // Undelayed relay request
	input wire logic [W-1:0] on_dly, // Turn-on delay, ms
	input wire logic [W-1:0] off_dly, // Turn-off delay, ms
	output logic state // Delayed relay state
);
	logic [W-1:0] cnt_reg; // Elapsed ms of pending change
	logic [W-1:0] cnt_next;
	logic st_reg; // Relay state
	logic st_next;

	// ==========================================================
	// Pending change timer
	// A request that falls back before expiry zeroes the count, so a
	// later change always waits the full delay again.
	always_comb begin
		cnt_next = cnt_reg;
		st_next = st_reg;
		if (req == st_reg) begin
			cnt_next = '0;
		end else if (cnt_reg >= (req ? on_dly : off_dly)) begin
			st_next = req;
			cnt_next = '0;
		end else if (tick) begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			st_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			st_reg <= st_next;
		end
	end

	assign state = st_reg;
endmodule

// file: core/drc_core.sv
/*
 Output-side supervision of a motor drive: fault relay cause logic with
 delays, auxiliary relays, cooling fan, input polarity and serial link
 supervision, all behind an APB slave.
 Assumes all inputs are synchronous to MCLK and the APB master is on MCLK.
*/
// Notes on behaviour
// - Undervoltage trip drives relay when enabled
// - Other faults except disable drive relay
// - Retry cause once count zero, not retrying
// - Cause priority: undervoltage, trip, retry
// - Eight-bit output status word, read-only
// - Programmable relay on and off delays
// - Fan modes: power, running, over temperature
// - Fan threshold 0 to 70, default 70
// - Remote-status contact closes under remote control
// - Station number register, default one
// - Baud select, default 9600, host matches
// - Loss action: none, coast, or stop
// - Loss declared after programmable timeout
// - Lost-remote indication raised on loss
// - Serial reply delay, default 5 ms
// - Per-input normally-open or normally-closed polarity
// - Each aux relay has its own function
`timescale 1ns/1ps
`include "drc_defines.svh"
module drc_core
	import drc_pkg::*;
#(
	parameter int TICK_CYCLES = `DRC_TICK_NS / `DRC_CLK_PERIOD_NS,
	parameter int NAUX = 4
) (
	input wire logic MCLK, // Core clock, 200 MHz
	input wire logic RST, // Async reset, high
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB access phase
	input wire logic PWRITE, // APB direction
	input wire logic [7:0] PADDR, // APB byte address
	input wire logic [31:0] PWDATA, // APB write data
	output logic [31:0] PRDATA, // APB read data
	output logic PREADY, // APB ready
	output logic PSLVERR, // APB error, unmapped
	input wire logic UNDERVOLTAGE_CAUSE, // Low-voltage trip
	input wire logic GEN_TRIP, // Any other trip
	input wire logic INVERTER_DISABLE_FAULT, // Disable fault
	input wire logic [7:0] AUTO_RETRY_COUNT, // Retries left
	input wire logic AUTO_RETRY_ON, // Retry in progress
	input wire logic [2:0] TR_STATE, // Transistor outputs
	input wire logic [28:0] AUX_COND, // Aux conditions, codes 1..29
	input wire logic REMOTE_CONTROL_INDICATION, // Remote control
	input wire logic POWER_OK, // Power present
	input wire logic RUNNING, // Outputting frequency
	input wire logic [7:0] DRIVE_TEMP, // Drive temperature, C
	input wire logic [7:0] DIN_CLOSED, // Raw contacts, 1 closed
	input wire logic COMM_ACT, // Valid frame pulse
	input wire logic FRAME_END, // Request end pulse
	output logic FAULT_RELAY_CONTACT, // Fault relay
	output logic [NAUX-1:0] AUX_RELAY, // Aux relays
	output logic FAN_ON, // Cooling fan
	output logic [7:0] DIN_ACTIVE, // Inputs after polarity
	output logic [7:0] STATION_ID, // Node number
	output logic [2:0] BAUD_SEL, // Bit rate code
	output logic LOST_REMOTE_INDICATION, // Link lost
	output logic COAST_ON_LINK_LOSS, // Cut output
	output logic STOP_ON_LINK_LOSS, // Decelerate to stop
	output logic REPLY_ALLOW, // Reply may start
	output logic IRQ // Interrupt, high
);
	// ==========================================================
	// Declarations
	logic tick; // Millisecond enable
	logic relay_state; // Delayed relay
	logic [2:0] cause_reg, cause_next; // Cause enables
	logic [7:0] inpol_reg, inpol_next; // Input polarity
	logic [15:0] on_dly_reg, on_dly_next; // Relay on delay
	logic [15:0] off_dly_reg, off_dly_next; // Relay off delay
	logic [1:0] fan_mode_reg, fan_mode_next; // Fan mode
	logic [6:0] fan_temp_reg, fan_temp_next; // Fan threshold
	logic [4:0] auxfn_reg [NAUX], auxfn_next [NAUX]; // Aux functions
	logic [7:0] station_reg, station_next; // Node number
	logic [2:0] baud_reg, baud_next; // Rate code
	logic [1:0] loss_reg, loss_next; // Loss action
	logic [15:0] tmo_reg, tmo_next; // Loss timeout, ms
	logic [7:0] sdly_reg, sdly_next; // Reply delay, ms
	logic [2:0] irq_stat_reg, irq_stat_next; // Sticky events
	logic [2:0] irq_mask_reg, irq_mask_next; // Event mask
	logic [31:0] rdata_reg, rdata_next; // Read data
	logic ready_reg, ready_next; // Access-phase ready
	logic err_reg, err_next; // Unmapped access
	logic wr; // Write commit
	logic fault_req; // Undelayed request
	logic [1:0] code; // Winning cause
	logic [31:0] cond; // Aux condition vector
	logic [NAUX-1:0] aux_reg, aux_next; // Aux relays
	logic fan_reg, fan_next; // Fan
	logic [7:0] din_reg, din_next; // Polarity applied
	drc_link_t link_reg, link_next; // Link watchdog state
	logic [15:0] idle_reg, idle_next; // Ms since last frame
	logic coast_reg, coast_next; // Coast output
	logic stop_reg, stop_next; // Stop output
	logic [7:0] rcnt_reg, rcnt_next; // Reply delay count
	logic rbusy_reg, rbusy_next; // Reply delay running
	logic rallow_reg, rallow_next; // Reply allowed
	logic relay_prev_reg; // For rising edge
	logic irq_reg, irq_next; // Interrupt
	logic [2:0] ev; // Events this cycle
	logic [NAUX-1:0] aux_next_w; // Selected conditions

	// Picks the condition selected for one aux relay
	function automatic logic aux_pick(input logic [4:0] sel, input logic [31:0] v);
		aux_pick = v[sel];
	endfunction

	// ==========================================================
	// Submodules
	drc_tick #(.DIV(TICK_CYCLES)) u_tick (
		.clk(MCLK),
		.rst(RST),
		.tick(tick)
	);

	drc_delay #(.W(16)) u_delay (
		.clk(MCLK),
		.rst(RST),
		.tick(tick),
		.req(fault_req),
		.on_dly(on_dly_reg),
		.off_dly(off_dly_reg),
		.state(relay_state)
	);

	// ==========================================================
	// Fault cause evaluation
	// Priority only picks the reported code; the relay closes on any
	// enabled cause.
	always_comb begin
		code = `DRC_CODE_NONE;
		if (UNDERVOLTAGE_CAUSE && cause_reg[`DRC_CB_UV]) begin
			code = `DRC_CODE_UV;
		end else if (GEN_TRIP && !INVERTER_DISABLE_FAULT && cause_reg[`DRC_CB_TRIP]) begin
			code = `DRC_CODE_TRIP;
		end else if ((GEN_TRIP || UNDERVOLTAGE_CAUSE) && AUTO_RETRY_COUNT == 8'h00 &&
			!AUTO_RETRY_ON && cause_reg[`DRC_CB_RETRY]) begin
			code = `DRC_CODE_RETRY;
		end
		fault_req = (code != `DRC_CODE_NONE);
	end

	// ==========================================================
	// Aux relays, fan and input polarity
	assign cond = {REMOTE_CONTROL_INDICATION, fan_reg, AUX_COND, 1'b0};
	always_comb begin
		for (int i = 0; i < NAUX; i++) begin
			aux_next[i] = aux_next_w[i];
		end
		case (drc_fan_mode_t'(fan_mode_reg))
			DRC_FAN_ALWAYS: fan_next = POWER_OK;
			DRC_FAN_RUN: fan_next = POWER_OK && RUNNING;
			DRC_FAN_TEMP: fan_next = POWER_OK && (DRIVE_TEMP > {1'b0, fan_temp_reg});
			default: fan_next = POWER_OK;
		endcase
		din_next = DIN_CLOSED ^ inpol_reg;
	end

	// One selector per relay; code 31 is remote status
	generate
		for (genvar g = 0; g < NAUX; g++) begin : g_aux
			assign aux_next_w[g] = aux_pick(auxfn_reg[g], cond);
		end
	endgenerate
	// Relays follow their selected condition one cycle later

	// ==========================================================
	// Link watchdog, loss action and reply delay
	// No loss is declared before the first frame, so a drive with no
	// host attached never trips on power-up.
	always_comb begin
		link_next = link_reg;
		idle_next = idle_reg;
		if (COMM_ACT) begin
			link_next = DRC_LINK_OK;
			idle_next = '0;
		end else begin
			case (link_reg)
				DRC_LINK_IDLE: idle_next = '0;
				DRC_LINK_OK: begin
					if (idle_reg >= tmo_reg) begin
						link_next = DRC_LINK_LOST;
					end else if (tick) begin
						idle_next = idle_reg + 16'h0001;
					end
				end
				DRC_LINK_LOST: idle_next = idle_reg;
				default: link_next = DRC_LINK_IDLE;
			endcase
		end
		coast_next = (link_next == DRC_LINK_LOST) && (loss_reg == 2'(DRC_LOSS_COAST));
		stop_next = (link_next == DRC_LINK_LOST) && (loss_reg == 2'(DRC_LOSS_STOP));
		rcnt_next = rcnt_reg;
		rbusy_next = rbusy_reg;
		rallow_next = rallow_reg;
		if (FRAME_END) begin
			rcnt_next = '0;
			rbusy_next = 1'b1;
			rallow_next = 1'b0;
		end else if (rbusy_reg) begin
			if (rcnt_reg >= sdly_reg) begin
				rbusy_next = 1'b0;
				rallow_next = 1'b1;
			end else if (tick) begin
				rcnt_next = rcnt_reg + 8'h01;
			end
		end
	end

	// ==========================================================
	// APB slave and register file
	// Ready rises in the first access cycle, so every transfer has one.
	assign wr = PSEL && PENABLE && ready_reg && PWRITE;
	assign ev[`DRC_IRQ_LOST] = (link_next == DRC_LINK_LOST) && (link_reg != DRC_LINK_LOST);
	assign ev[`DRC_IRQ_RELAY] = relay_state && !relay_prev_reg;
	assign ev[`DRC_IRQ_RESTORE] = (link_reg == DRC_LINK_LOST) && COMM_ACT;
	always_comb begin
		cause_next = cause_reg;
		inpol_next = inpol_reg;
		on_dly_next = on_dly_reg;
		off_dly_next = off_dly_reg;
		fan_mode_next = fan_mode_reg;
		fan_temp_next = fan_temp_reg;
		auxfn_next = auxfn_reg;
		station_next = station_reg;
		baud_next = baud_reg;
		loss_next = loss_reg;
		tmo_next = tmo_reg;
		sdly_next = sdly_reg;
		irq_mask_next = irq_mask_reg;
		irq_stat_next = irq_stat_reg;
		if (wr) begin
			case (PADDR)
				`DRC_OFF_CAUSE: cause_next = PWDATA[2:0];
				`DRC_OFF_INPOL: inpol_next = PWDATA[7:0];
				`DRC_OFF_ON_DLY: on_dly_next = PWDATA[15:0];
				`DRC_OFF_OFF_DLY: off_dly_next = PWDATA[15:0];
				`DRC_OFF_FAN: begin
					fan_mode_next = PWDATA[1:0];
					// Clamp to the top of the allowed range
					fan_temp_next = (PWDATA[14:8] > `DRC_FAN_TEMP_MAX) ?
						`DRC_FAN_TEMP_MAX : PWDATA[14:8];
				end
				`DRC_OFF_AUXFN: begin
					for (int i = 0; i < NAUX; i++) begin
						auxfn_next[i] = PWDATA[8*i +: 5];
					end
				end
				`DRC_OFF_COMM: begin
					station_next = PWDATA[7:0];
					baud_next = PWDATA[10:8];
					loss_next = PWDATA[13:12];
				end
				`DRC_OFF_TIMEOUT: tmo_next = PWDATA[15:0];
				`DRC_OFF_SDELAY: sdly_next = PWDATA[7:0];
				`DRC_OFF_IRQ_STAT: irq_stat_next = irq_stat_reg & ~PWDATA[2:0];
				`DRC_OFF_IRQ_MASK: irq_mask_next = PWDATA[2:0];
				default: ;
			endcase
		end
		irq_stat_next = irq_stat_next | ev; // Set beats clear
		irq_next = |(irq_stat_reg & irq_mask_reg);
		ready_next = PSEL && !PENABLE;
		rdata_next = rdata_reg;
		err_next = 1'b0;
		if (PSEL && !PENABLE) begin
			rdata_next = 32'h0000_0000;
			case (PADDR)
				`DRC_OFF_CAUSE: rdata_next[2:0] = cause_reg;
				`DRC_OFF_OUTSTAT: rdata_next[7:0] = {relay_state, TR_STATE, aux_reg};
				`DRC_OFF_INPOL: rdata_next[7:0] = inpol_reg;
				`DRC_OFF_ON_DLY: rdata_next[15:0] = on_dly_reg;
				`DRC_OFF_OFF_DLY: rdata_next[15:0] = off_dly_reg;
				`DRC_OFF_FAN: rdata_next[14:0] = {fan_temp_reg, 6'h00, fan_mode_reg};
				`DRC_OFF_AUXFN: begin
					for (int i = 0; i < NAUX; i++) begin
						rdata_next[8*i +: 5] = auxfn_reg[i];
					end
				end
				`DRC_OFF_COMM: rdata_next[13:0] = {loss_reg, 1'b0, baud_reg, station_reg};
				`DRC_OFF_TIMEOUT: rdata_next[15:0] = tmo_reg;
				`DRC_OFF_SDELAY: rdata_next[7:0] = sdly_reg;
				`DRC_OFF_STATUS: rdata_next[13:0] = {code, 2'h0, fan_reg,
					(link_reg == DRC_LINK_LOST), din_reg};
				`DRC_OFF_IRQ_STAT: rdata_next[2:0] = irq_stat_reg;
				`DRC_OFF_IRQ_MASK: rdata_next[2:0] = irq_mask_reg;
				default: err_next = 1'b1; // Unmapped, reads zero
			endcase
		end else begin
			err_next = 1'b0; // Error stands only with ready
		end
	end

	// Registers every state group
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			cause_reg <= `DRC_RST_CAUSE;
			inpol_reg <= `DRC_RST_INPOL;
			on_dly_reg <= `DRC_RST_RELAY_DLY;
			off_dly_reg <= `DRC_RST_RELAY_DLY;
			fan_mode_reg <= `DRC_RST_FAN_MODE;
			fan_temp_reg <= `DRC_RST_FAN_TEMP;
			for (int i = 0; i < NAUX; i++) begin
				auxfn_reg[i] <= 5'h00;
			end
			station_reg <= `DRC_RST_STATION;
			baud_reg <= `DRC_RST_BAUD;
			loss_reg <= `DRC_RST_LOSS_ACT;
			tmo_reg <= `DRC_RST_TIMEOUT_MS;
			sdly_reg <= `DRC_RST_SDELAY_MS;
			irq_stat_reg <= 3'h0;
			irq_mask_reg <= 3'h0;
			irq_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			ready_reg <= 1'b0;
			err_reg <= 1'b0;
			aux_reg <= '0;
			fan_reg <= 1'b0;
			din_reg <= 8'h00;
			link_reg <= DRC_LINK_IDLE;
			idle_reg <= 16'h0000;
			coast_reg <= 1'b0;
			stop_reg <= 1'b0;
			rcnt_reg <= 8'h00;
			rbusy_reg <= 1'b0;
			rallow_reg <= 1'b0;
			relay_prev_reg <= 1'b0;
		end else begin
			cause_reg <= cause_next;
			inpol_reg <= inpol_next;
			on_dly_reg <= on_dly_next;
			off_dly_reg <= off_dly_next;
			fan_mode_reg <= fan_mode_next;
			fan_temp_reg <= fan_temp_next;
			auxfn_reg <= auxfn_next;
			station_reg <= station_next;
			baud_reg <= baud_next;
			loss_reg <= loss_next;
			tmo_reg <= tmo_next;
			sdly_reg <= sdly_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			irq_reg <= irq_next;
			rdata_reg <= rdata_next;
			ready_reg <= ready_next;
			err_reg <= err_next;
			aux_reg <= aux_next;
			fan_reg <= fan_next;
			din_reg <= din_next;
			link_reg <= link_next;
			idle_reg <= idle_next;
			coast_reg <= coast_next;
			stop_reg <= stop_next;
			rcnt_reg <= rcnt_next;
			rbusy_reg <= rbusy_next;
			rallow_reg <= rallow_next;
			relay_prev_reg <= relay_state;
		end
	end

	// ==========================================================
	// Outputs, all from flip-flops except LOST_REMOTE_INDICATION, decoded from link_reg
	assign PRDATA = rdata_reg;
	assign PREADY = ready_reg;
	assign PSLVERR = err_reg;
	assign FAULT_RELAY_CONTACT = relay_state;
	assign AUX_RELAY = aux_reg;
	assign FAN_ON = fan_reg;
	assign DIN_ACTIVE = din_reg;
	assign STATION_ID = station_reg;
	assign BAUD_SEL = baud_reg;
	assign LOST_REMOTE_INDICATION = (link_reg == DRC_LINK_LOST);
	assign COAST_ON_LINK_LOSS = coast_reg;
	assign STOP_ON_LINK_LOSS = stop_reg;
	assign REPLY_ALLOW = rallow_reg;
	assign IRQ = irq_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);

	sequence s_req_held;
		fault_req && !FAULT_RELAY_CONTACT && on_dly_reg == 16'h0000;
	endsequence
	property p_uv_cause;
		UNDERVOLTAGE_CAUSE && cause_reg[`DRC_CB_UV] |-> fault_req && code == `DRC_CODE_UV;
	endproperty
	a_uv_cause: assert property (p_uv_cause) else $error("uv cause lost");
	property p_trip_cause;
		!cause_reg[`DRC_CB_TRIP] && !cause_reg[`DRC_CB_RETRY] && !UNDERVOLTAGE_CAUSE
			|-> !fault_req;
	endproperty
	a_trip_cause: assert property (p_trip_cause) else $error("trip not gated");
	property p_retry_block;
		AUTO_RETRY_ON |-> code != `DRC_CODE_RETRY;
	endproperty
	a_retry_block: assert property (p_retry_block) else $error("retry while retrying");
	property p_zero_on_dly;
		s_req_held ##1 fault_req |-> FAULT_RELAY_CONTACT;
	endproperty
	a_zero_on_dly: assert property (p_zero_on_dly) else $error("zero delay late");
	property p_relay_edge;
		$rose(FAULT_RELAY_CONTACT) |-> $past(fault_req);
	endproperty
	a_relay_edge: assert property (p_relay_edge) else $error("relay without req");
	property p_fan_always;
		fan_mode_reg == 2'(DRC_FAN_ALWAYS) && POWER_OK |=> FAN_ON;
	endproperty
	a_fan_always: assert property (p_fan_always) else $error("fan off");
	property p_fan_temp_max;
		fan_temp_reg <= `DRC_FAN_TEMP_MAX;
	endproperty
	a_fan_temp_max: assert property (p_fan_temp_max) else $error("fan temp range");
	property p_lost_timeout;
		$rose(LOST_REMOTE_INDICATION) |-> $past(idle_reg) >= $past(tmo_reg);
	endproperty
	a_lost_timeout: assert property (p_lost_timeout) else $error("early loss");
	property p_din_pol;
		##1 DIN_ACTIVE == ($past(DIN_CLOSED) ^ $past(inpol_reg));
	endproperty
	a_din_pol: assert property (p_din_pol) else $error("polarity wrong");
endmodule

// file: bench/drc_host_model.sv
/*
 Host side model: RS-485 host that sends one frame per request.
 Assumes the core clock and a one-cycle go pulse from the bench.
*/
`timescale 1ns/1ps
module drc_host_model #(
	parameter logic [2:0] HOST_BAUD = 3'h3 // Host bit rate code
) (
	input wire logic clk, // Core clock
	input wire logic go, // Send one frame
	input wire logic [2:0] baud_sel, // Device rate code
	output logic comm_act, // Valid frame seen
	output logic frame_end // Request finished
);
	// ==========
	// Frame pulses
	initial begin
		comm_act = 1'b0;
		frame_end = 1'b0;
	end
	// At a foreign rate only garbage arrives, so no frame is seen
	always @(posedge clk) begin
		comm_act <= go && (baud_sel === HOST_BAUD); // Rates match
		frame_end <= comm_act; // End follows frame
	end
endmodule

// file: bench/drc_core_tb_top.sv
/*
 Bench for the drive output and serial supervision core.
 Assumes drc_defines.svh on the include path; short tick for speed.
*/
`timescale 1ns/1ps
`include "drc_defines.svh"
`define CHK(g, w) begin samples_checked++; if ((g) !== (w)) begin fails++; \
	$display("unexpected at %0t: got %h want %h", $time, g, w); end end
module drc_core_tb_top;
	// ==========
	// Stimulus and observation
	logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, slverr;
	logic [7:0] paddr = 0, ar_cnt = 0, temp = 0, din = 0, dina, stn;
	logic [31:0] pwdata = 0, prdata, rv;
	logic uv = 0, trip = 0, dis = 0, ar_on = 0, rmt = 0, pwr = 0, run = 0, go = 0;
	logic [2:0] tr = 0, baud;
	logic [28:0] aux = 0;
	logic [3:0] auxr;
	logic pready, relay, fan, lost, coast, stopl, rply, irq, comm, fend, se;
	int fails = 0, samples_checked = 0;
	drc_core #(.TICK_CYCLES(4)) drc_core_i(.MCLK(mclk), .RST(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(slverr), .UNDERVOLTAGE_CAUSE(uv),
		.GEN_TRIP(trip), .INVERTER_DISABLE_FAULT(dis), .AUTO_RETRY_COUNT(ar_cnt),
		.AUTO_RETRY_ON(ar_on), .TR_STATE(tr), .AUX_COND(aux),
		.REMOTE_CONTROL_INDICATION(rmt), .POWER_OK(pwr), .RUNNING(run),
		.DRIVE_TEMP(temp), .DIN_CLOSED(din), .COMM_ACT(comm), .FRAME_END(fend),
		.FAULT_RELAY_CONTACT(relay), .AUX_RELAY(auxr), .FAN_ON(fan), .DIN_ACTIVE(dina),
		.STATION_ID(stn), .BAUD_SEL(baud), .LOST_REMOTE_INDICATION(lost),
		.COAST_ON_LINK_LOSS(coast), .STOP_ON_LINK_LOSS(stopl), .REPLY_ALLOW(rply),
		.IRQ(irq));
	drc_host_model drc_host_model_i(.clk(mclk), .go(go), .baud_sel(baud),
		.comm_act(comm), .frame_end(fend));
	// Free-running 200 MHz clock
	initial begin
		forever #2.5 mclk = ~mclk;
	end
	// ==========
	// Bus and helpers
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// One APB transfer; waits for ready, idles one cycle after
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1);
		rv = prdata;
		se = slverr;
		psel <= 0;
		penable <= 0;
		@(posedge mclk);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ==========
	// Scenarios
	task automatic t_defaults();
		apb(0, `DRC_OFF_CAUSE, 0);
		`CHK(rv, 32'h2) // Cause default
		apb(0, `DRC_OFF_COMM, 0);
		`CHK(rv[7:0], 8'h01) // Station
		`CHK(rv[10:8], 3'h3) // Rate
		apb(0, `DRC_OFF_TIMEOUT, 0);
		`CHK(rv, 32'h3E8) // Timeout
		apb(0, `DRC_OFF_SDELAY, 0);
		`CHK(rv, 32'h5) // Reply delay
		apb(0, `DRC_OFF_FAN, 0);
		`CHK(rv, 32'h4600) // Fan setup
		apb(1, `DRC_OFF_OUTSTAT, 32'hFF);
		apb(0, `DRC_OFF_OUTSTAT, 0);
		`CHK(rv, 32'h0) // Read-only word
		apb(0, 8'h3C, 0);
		`CHK({se, rv}, 33'h1_0000_0000)
	endtask
	// Relay moves one edge after the request; irq two edges after that
	task automatic t_causes();
		apb(1, `DRC_OFF_IRQ_MASK, 32'h2);
		apb(1, `DRC_OFF_CAUSE, 0);
		uv <= 1;
		step(3);
		`CHK(relay, 1'b0) // Cause off
		apb(1, `DRC_OFF_CAUSE, 32'h1);
		step(3);
		`CHK({relay, irq}, 2'b11) // Relay and irq
		trip <= 1;
		apb(1, `DRC_OFF_CAUSE, 32'h3);
		apb(0, `DRC_OFF_STATUS, 0);
		`CHK(rv[13:12], 2'h1) // Undervoltage first
		apb(0, `DRC_OFF_OUTSTAT, 0);
		`CHK(rv[7], 1'b1) // Relay bit
		{uv, trip} <= 0;
		step(3);
		`CHK(relay, 1'b0) // Zero off delay
		apb(1, `DRC_OFF_IRQ_STAT, 32'h2);
		step(1);
		`CHK(irq, 1'b0) // Cleared
		{trip, dis} <= 2'b11;
		step(3);
		`CHK(relay, 1'b0) // Disable masks
		dis <= 0;
		step(3);
		`CHK(relay, 1'b1) // Trip drives
		ar_on <= 1;
		apb(1, `DRC_OFF_CAUSE, 32'h4);
		step(1);
		`CHK(relay, 1'b0) // Retry active
		ar_on <= 0;
		step(3);
		`CHK(relay, 1'b1) // Retries used up
		trip <= 0;
		step(3);
	endtask
	// Short tick: 4 cycles per ms, first tick may be partial
	task automatic t_delays();
		apb(1, `DRC_OFF_CAUSE, 32'h2);
		apb(1, `DRC_OFF_ON_DLY, 32'h2);
		apb(1, `DRC_OFF_OFF_DLY, 32'h2);
		trip <= 1;
		step(3);
		`CHK(relay, 1'b0) // Still waiting
		step(13);
		`CHK(relay, 1'b1) // On after delay
		trip <= 0;
		step(2);
		trip <= 1;
		step(14);
		`CHK(relay, 1'b1) // Timer restarted
		trip <= 0;
		step(16);
		`CHK(relay, 1'b0) // Off after delay
	endtask
	// Outputs lag their inputs by one edge after a register write lands
	task automatic t_inputs();
		din <= 8'hA5;
		pwr <= 1;
		apb(1, `DRC_OFF_INPOL, 32'hF0);
		step(1);
		`CHK({dina, fan}, 9'h0AB) // Polarity and fan
		temp <= 71;
		apb(1, `DRC_OFF_FAN, 32'h4602);
		step(1);
		`CHK(fan, 1'b1) // Above threshold
		temp <= 70;
		step(2);
		`CHK(fan, 1'b0) // Not above
		run <= 1;
		apb(1, `DRC_OFF_FAN, 32'h4601);
		step(1);
		`CHK(fan, 1'b1) // Runs with the drive
		rmt <= 1;
		aux <= 1;
		apb(1, `DRC_OFF_AUXFN, 32'h011F);
		step(1);
		`CHK(auxr, 4'h3) // Remote and code one
		rmt <= 0;
		step(2);
		`CHK(auxr, 4'h2) // Independent relays
	endtask
	task automatic t_link();
		apb(1, `DRC_OFF_TIMEOUT, 32'h3);
		apb(1, `DRC_OFF_SDELAY, 32'h2);
		apb(1, `DRC_OFF_COMM, 32'h1307);
		`CHK({stn, baud}, 11'h03B) // Node and rate
		go <= 1;
		step(1);
		go <= 0;
		step(3);
		`CHK({lost, rply}, 2'b00) // Not yet lost
		step(20);
		`CHK({lost, coast, stopl, rply}, 4'b1101) // Coasting
		go <= 1;
		step(1);
		go <= 0;
		step(3);
		`CHK({lost, rply}, 2'b00) // Frame clears
		// Rate code 0 differs from the host, so its frame goes unheard
		apb(1, `DRC_OFF_COMM, 32'h2007);
		go <= 1;
		step(1);
		go <= 0;
		step(20);
		`CHK({lost, coast, stopl, baud}, 6'b101000) // Stop
		apb(0, `DRC_OFF_IRQ_STAT, 0);
		`CHK(rv, 32'h7) // Lost, relay, restore events
	endtask
	// ==========
	// Sequence and watchdog
	initial begin
		step(2);
		rst <= 0;
		t_defaults();
		t_causes();
		t_delays();
		t_inputs();
		t_link();
		results();
	end
	initial begin
		step(3000);
		fails++;
		results();
	end
endmodule
